/* hw/thermo_pkg.sv */
// Package: constants, carriers and states of the thermometer function layer
package thermo_pkg;
  // Clock and time base
  localparam int CLK_HZ = 25_000_000; // System clock, 40 ns period
  localparam int US_PER_S = 1_000_000; // Microseconds per second
  localparam int CYC_PER_US = CLK_HZ / US_PER_S; // Cycles per microsecond tick
  localparam int SAMPLE_US = 30; // Write sample point, inside the 15..60 us window
  localparam int RESET_US = 480; // Low time that counts as a bus reset

  // Command bytes
  localparam logic [7:0] CMD_SEARCH = 8'hF0; // Normal identifier search
  localparam logic [7:0] CMD_ALARM_SEARCH = 8'hEC; // Search limited to alarmed parts
  localparam logic [7:0] CMD_CONVERT = 8'h44; // Start one conversion
  localparam logic [7:0] CMD_WRITE_MEM = 8'h4E; // Write three working bytes
  localparam logic [7:0] CMD_READ_MEM = 8'hBE; // Read the working memory
  localparam logic [7:0] CMD_COPY = 8'h48; // Working bytes to nonvolatile store
  localparam logic [7:0] RELOAD_NONVOLATILE_CMD = 8'hB8; // Nonvolatile store to working bytes
  localparam logic [7:0] CMD_SUPPLY_QUERY = 8'hB4; // Report supply mode

  // Working memory byte indexes
  localparam logic [3:0] IDX_TEMP_LO = 4'h0; // Temperature result, low byte
  localparam logic [3:0] IDX_TEMP_HI = 4'h1; // Temperature result, high byte
  localparam logic [3:0] IDX_HIGH_ALARM = 4'h2; // High alarm threshold
  localparam logic [3:0] IDX_LOW_ALARM = 4'h3; // Low alarm threshold
  localparam logic [3:0] IDX_CONFIG = 4'h4; // Configuration byte
  localparam logic [3:0] IDX_CHECK = 4'h8; // Memory check byte
  localparam logic [3:0] MEM_BYTES = 4'h9; // Bytes in one full read
  localparam logic [1:0] WR_LAST = 2'h2; // Index of last written data byte

  // Reset and fill values
  localparam logic [7:0] RSV_BYTE = 8'hFF; // Bytes 5..7 read as this
  localparam logic [15:0] TEMP_RST = 16'h0000; // Temperature before first conversion
  localparam logic [23:0] NV_RST = 24'h000000; // Working bytes before power-up reload

  // Thresholds and configuration, as stored and as held
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] tl;
    logic [7:0] th;
  } nv_data_t;

  // Line events from the slot timer: one-cycle pulses plus the line level
  typedef struct packed {
    logic start; // Falling edge opened a slot
    logic smp; // Sample point reached
    logic lvl; // Filtered line level
    logic rst; // Line held low for a reset
  } slot_ev_t;

  // Function layer states
  typedef enum logic [7:0] {
    S_IDLE = 8'b0000_0001,
    S_CMD = 8'b0000_0010,
    S_WRITE = 8'b0000_0100,
    S_READ = 8'b0000_1000,
    S_STATUS = 8'b0001_0000,
    S_POWER = 8'b0010_0000,
    S_COPY = 8'b0100_0000,
    S_DEAD = 8'b1000_0000
  } state_t;
endpackage

/* hw/line_slot_timer.sv */
// Module: line filter, microsecond tick, slot and reset timing
`timescale 1ns/1ps
module line_slot_timer
  import thermo_pkg::*;
#(
  parameter int DIV = CYC_PER_US
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dq_in,
  output slot_ev_t ev
);
  localparam int DW = $clog2(DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1); // Last divider count
  localparam logic [9:0] RST_CNT = 10'(RESET_US); // Reset low time in ticks
  localparam logic [5:0] SMP_CNT = 6'(SAMPLE_US); // Sample point in ticks

  logic s1_reg, s2_reg, s3_reg; // Three-stage line synchroniser
  logic lvl_reg; // Accepted line level
  logic [DW-1:0] div_reg; // Microsecond divider
  logic us_tick; // One-cycle microsecond enable
  logic [9:0] low_us_reg; // Time the line has been low
  logic [5:0] slot_us_reg; // Time since slot opened
  logic armed_reg; // Slot open, sample pending
  logic fall, line_rst, smp;
  slot_ev_t ev_reg;

  // Stage one feeds only stage two
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      s1_reg <= dq_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once stages two and three agree
  assign fall = (s2_reg == s3_reg) && !s3_reg && lvl_reg;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lvl_reg <= 1'b1;
    end else if (s2_reg == s3_reg) begin
      lvl_reg <= s3_reg;
    end
  end

  // Free-running microsecond enable
  assign us_tick = (div_reg == DIV_LAST);
  always_ff @(posedge clk) begin
    if (!rstn || us_tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // Long low time detection, fires once per low period
  assign line_rst = us_tick && !lvl_reg && (low_us_reg == RST_CNT - 10'h001); // RULE21
  always_ff @(posedge clk) begin
    if (!rstn || lvl_reg) begin
      low_us_reg <= '0;
    end else if (us_tick && low_us_reg != RST_CNT) begin
      low_us_reg <= low_us_reg + 10'h001;
    end
  end

  // Slot timer; tick phase gives up to 1 us of jitter, well inside the window
  assign smp = armed_reg && us_tick && (slot_us_reg == SMP_CNT - 6'h01); // RULE19
  always_ff @(posedge clk) begin
    if (!rstn) begin
      slot_us_reg <= '0;
      armed_reg <= 1'b0;
    end else if (fall) begin
      slot_us_reg <= '0;
      armed_reg <= 1'b1;
    end else if (smp) begin
      armed_reg <= 1'b0;
    end else if (armed_reg && us_tick) begin
      slot_us_reg <= slot_us_reg + 6'h01;
    end
  end

  // Registered events
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ev_reg <= '{start: 1'b0, smp: 1'b0, lvl: 1'b1, rst: 1'b0};
    end else begin
      ev_reg <= '{start: fall, smp: smp, lvl: lvl_reg, rst: line_rst};
    end
  end
  assign ev = ev_reg;
endmodule // line_slot_timer

/* hw/thermometer_function_commands.sv */
// Module: function command layer of the single-wire thermometer
//
// Overview of operation
// RULE1: Alarm search joins only with alarm flag
// RULE2: Master resets after each alarm search cycle
// RULE3: Function commands accepted only when addressed
// RULE4: Convert command starts conversion, stores result
// RULE5: Parasite master applies strong pullup within 10us
// RULE6: External supply: read slots report conversion busy
// RULE7: Write command fills bytes 2,3,4 in order
// RULE8: Master sends all three bytes before reset
// RULE9: Read command sends bytes 0..8, LSB first
// RULE10: Reset aborts a read at any point
// RULE11: Copy stores bytes 2..4, bus stays quiet
// RULE12: Parasite copy needs pullup at least 10ms
// RULE13: Reload command restores bytes 2,3,4
// RULE14: Read slots report reload busy as 0
// RULE15: Reload runs automatically after power-up
// RULE16: Supply query: parasite drives low, else high
// RULE17: No bus activity during strong pullup
// RULE18: All bytes travel least significant bit first
// RULE19: Write slot sampled between 15 and 60us
// RULE20: Read zero pulls low, released before slot end
// RULE21: Low over 480us abandons command as reset
// RULE22: Unknown command ignored, silent until reset
`timescale 1ns/1ps
module thermometer_function_commands
  import thermo_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe_n,
  input wire logic addressed,
  input wire logic rom_cmd_stb,
  input wire logic [7:0] rom_cmd,
  input wire logic alarm_flag,
  input wire logic line_powered,
  input wire logic conv_done,
  input wire logic [15:0] conv_temp,
  input wire logic nv_rd_done,
  input wire nv_data_t nv_rdata,
  input wire logic [7:0] check_byte,
  output logic bus_reset,
  output logic search_part,
  output logic conv_start,
  output logic nv_wr_stb,
  output nv_data_t nv_wdata,
  output logic nv_rd_req,
  output nv_data_t wm_out
);
  slot_ev_t ev; // Line events
  state_t state_reg, state_next; // Command state
  logic [2:0] bit_cnt_reg; // Received bits in byte
  logic [7:0] shift_reg; // Receive shifter
  logic [1:0] byte_cnt_reg; // Written data bytes
  logic rx_done; // Byte complete this cycle
  logic [7:0] rx_byte; // Byte completed this cycle
  logic cmd_hit; // Command byte complete
  nv_data_t wm_reg; // Working thresholds and configuration
  logic [15:0] temp_reg; // Temperature result
  logic conv_busy_reg, recall_busy_reg, status_conv_reg, powerup_reg;
  logic [7:0] fifo_mem [2]; // Two-entry read buffer
  logic wr_ptr_reg, rd_ptr_reg;
  logic [1:0] fifo_cnt_reg;
  logic push, pop;
  logic [3:0] rd_idx_reg; // Next memory byte to fetch
  logic [7:0] fetch_byte;
  logic [7:0] tx_reg; // Transmit shifter
  logic [3:0] tx_left_reg; // Bits left in transmit shifter
  logic drive_reg; // Pulling the line low
  logic busy_bit; // Status answer for this slot

  line_slot_timer u_slot (
    .clk(clk),
    .rstn(rstn),
    .dq_in(dq_in),
    .ev(ev)
  );

  // Byte assembly, least significant bit arrives first
  assign rx_done = ev.smp && (bit_cnt_reg == 3'h7) && (state_reg == S_CMD || state_reg == S_WRITE);
  assign rx_byte = {ev.lvl, shift_reg[7:1]}; // RULE18
  assign cmd_hit = rx_done && (state_reg == S_CMD);
  always_ff @(posedge clk) begin
    if (!rstn || ev.rst || state_reg == S_IDLE) begin
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      byte_cnt_reg <= '0;
    end else if (ev.smp && (state_reg == S_CMD || state_reg == S_WRITE)) begin
      shift_reg <= rx_byte; // RULE19
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (rx_done && state_reg == S_WRITE) begin
        byte_cnt_reg <= byte_cnt_reg + 2'h1;
      end
    end
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (addressed) begin
          state_next = S_CMD; // RULE3
        end
      end
      S_CMD: begin
        if (rx_done) begin
          case (rx_byte)
            CMD_CONVERT: state_next = S_STATUS;
            CMD_WRITE_MEM: state_next = S_WRITE;
            CMD_READ_MEM: state_next = S_READ;
            CMD_COPY: state_next = S_COPY;
            RELOAD_NONVOLATILE_CMD: state_next = S_STATUS;
            CMD_SUPPLY_QUERY: state_next = S_POWER;
            default: state_next = S_DEAD; // RULE22
          endcase
        end
      end
      S_WRITE: begin
        if (rx_done && byte_cnt_reg == WR_LAST) begin
          state_next = S_DEAD;
        end
      end
      S_POWER: begin
        // Leave at the sample point, so the answer's low drive is not cut short
        if (ev.smp) begin
          state_next = S_DEAD; // RULE16
        end
      end
      S_COPY: state_next = S_DEAD; // RULE11
      S_READ, S_STATUS, S_DEAD: state_next = state_reg;
      default: state_next = S_IDLE;
    endcase
  end

  // State register; a bus reset wins over everything
  always_ff @(posedge clk) begin
    if (!rstn || ev.rst) begin
      state_reg <= S_IDLE; // RULE21 RULE10
    end else begin
      state_reg <= state_next;
    end
  end

  // Working bytes: reload data beats a write in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wm_reg <= NV_RST;
      temp_reg <= TEMP_RST;
    end else begin
      if (conv_done) begin
        temp_reg <= conv_temp; // RULE4
      end
      if (nv_rd_done) begin
        wm_reg <= nv_rdata; // RULE13 RULE15
      end else if (rx_done && state_reg == S_WRITE) begin
        case (byte_cnt_reg)
          2'h0: wm_reg.th <= rx_byte; // RULE7
          2'h1: wm_reg.tl <= rx_byte;
          default: wm_reg.cfg <= rx_byte;
        endcase
      end
    end
  end

  // Conversion and nonvolatile requests; new requests win over completion
  always_ff @(posedge clk) begin
    if (!rstn) begin
      conv_start <= 1'b0;
      conv_busy_reg <= 1'b0;
      nv_rd_req <= 1'b0;
      recall_busy_reg <= 1'b0;
      powerup_reg <= 1'b1;
      nv_wr_stb <= 1'b0;
      nv_wdata <= NV_RST;
      status_conv_reg <= 1'b0;
    end else begin
      conv_start <= cmd_hit && rx_byte == CMD_CONVERT; // RULE4
      if (cmd_hit && rx_byte == CMD_CONVERT) begin
        conv_busy_reg <= 1'b1;
        status_conv_reg <= 1'b1;
      end else if (conv_done) begin
        conv_busy_reg <= 1'b0;
      end
      nv_rd_req <= (cmd_hit && rx_byte == RELOAD_NONVOLATILE_CMD) || powerup_reg; // RULE13 RULE15
      powerup_reg <= 1'b0;
      if ((cmd_hit && rx_byte == RELOAD_NONVOLATILE_CMD) || powerup_reg) begin
        recall_busy_reg <= 1'b1;
        if (cmd_hit) begin
          status_conv_reg <= 1'b0;
        end
      end else if (nv_rd_done) begin
        recall_busy_reg <= 1'b0;
      end
      nv_wr_stb <= (state_reg == S_COPY); // RULE11
      if (state_reg == S_COPY) begin
        nv_wdata <= wm_reg;
      end
    end
  end

  // Memory byte fetch for the read stream
  always_comb begin
    case (rd_idx_reg)
      IDX_TEMP_LO: fetch_byte = temp_reg[7:0];
      IDX_TEMP_HI: fetch_byte = temp_reg[15:8];
      IDX_HIGH_ALARM: fetch_byte = wm_reg.th;
      IDX_LOW_ALARM: fetch_byte = wm_reg.tl;
      IDX_CONFIG: fetch_byte = wm_reg.cfg;
      IDX_CHECK: fetch_byte = check_byte;
      default: fetch_byte = RSV_BYTE;
    endcase
  end

  // Two-entry buffer; a full buffer stalls the fetch side
  assign push = (state_reg == S_READ) && (fifo_cnt_reg != 2'h2) && (rd_idx_reg < MEM_BYTES); // RULE9
  assign pop = (state_reg == S_READ) && (tx_left_reg == 4'h0) && (fifo_cnt_reg != 2'h0);
  always_ff @(posedge clk) begin
    if (!rstn || ev.rst || state_reg != S_READ) begin
      rd_idx_reg <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      fifo_cnt_reg <= '0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_reg] <= fetch_byte;
        wr_ptr_reg <= ~wr_ptr_reg;
        rd_idx_reg <= rd_idx_reg + 4'h1;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // Status answer: parasite conversion cannot be reported
  assign busy_bit = status_conv_reg ? (conv_busy_reg && !line_powered) : recall_busy_reg; // RULE6 RULE14

  // Transmit shifter and line drive; hold low only to the sample point
  always_ff @(posedge clk) begin
    if (!rstn || ev.rst || state_reg == S_IDLE) begin
      drive_reg <= 1'b0; // RULE10
      tx_reg <= '0;
      tx_left_reg <= '0;
    end else if (ev.smp) begin
      drive_reg <= 1'b0; // RULE20
    end else if (ev.start) begin
      case (state_reg)
        S_READ: begin
          if (tx_left_reg != 4'h0) begin
            drive_reg <= !tx_reg[0]; // RULE18 RULE20
            tx_reg <= {1'b1, tx_reg[7:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
          end
        end
        S_STATUS: drive_reg <= busy_bit; // RULE6 RULE14
        S_POWER: drive_reg <= line_powered; // RULE16
        default: drive_reg <= 1'b0; // RULE22
      endcase
    end else if (pop) begin
      tx_reg <= fifo_mem[rd_ptr_reg];
      tx_left_reg <= 4'h8;
    end
  end

  // Search participation for the identifier layer
  always_ff @(posedge clk) begin
    if (!rstn || ev.rst) begin
      search_part <= 1'b0;
    end else if (rom_cmd_stb) begin
      search_part <= (rom_cmd == CMD_SEARCH) || (rom_cmd == CMD_ALARM_SEARCH && alarm_flag); // RULE1
    end
  end

  // Registered pin and status outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dq_out <= 1'b0;
      dq_oe_n <= 1'b1;
      bus_reset <= 1'b0;
      wm_out <= NV_RST;
    end else begin
      dq_out <= 1'b0;
      dq_oe_n <= !drive_reg;
      bus_reset <= ev.rst;
      wm_out <= wm_reg;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_copy_cmd;
    cmd_hit && rx_byte == CMD_COPY;
  endsequence
  sequence s_copy_done;
    ##1 (state_reg == S_COPY) ##1 (nv_wr_stb && state_reg == S_DEAD);
  endsequence

  property p_alarm_quiet;
    rom_cmd_stb && rom_cmd == CMD_ALARM_SEARCH && !alarm_flag && !ev.rst |=> !search_part;
  endproperty
  a_alarm_quiet: assert property (p_alarm_quiet) else $error("alarm search joined without flag"); // RULE1

  property p_addr_first;
    (state_reg == S_IDLE) && !addressed |=> (state_reg == S_IDLE);
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("command taken unaddressed"); // RULE3

  property p_conv;
    cmd_hit && rx_byte == CMD_CONVERT && !ev.rst |=> conv_start && conv_busy_reg && state_reg == S_STATUS;
  endproperty
  a_conv: assert property (p_conv) else $error("conversion not started"); // RULE4

  property p_parasite_conv;
    state_reg == S_STATUS && status_conv_reg && line_powered |=> !drive_reg;
  endproperty
  a_parasite_conv: assert property (p_parasite_conv) else $error("drove during parasite conversion"); // RULE6

  property p_write_th;
    rx_done && state_reg == S_WRITE && byte_cnt_reg == 2'h0 && !nv_rd_done |=> wm_reg.th == $past(rx_byte);
  endproperty
  a_write_th: assert property (p_write_th) else $error("high threshold not written"); // RULE7

  property p_copy;
    s_copy_cmd |-> s_copy_done;
  endproperty
  a_copy: assert property (p_copy) else $error("copy sequence wrong"); // RULE11

  property p_release;
    $rose(drive_reg) |-> ##[1:800] !drive_reg;
  endproperty
  a_release: assert property (p_release) else $error("line held past slot"); // RULE20

  property p_reset_abort;
    ev.rst |=> state_reg == S_IDLE && !drive_reg ##1 dq_oe_n;
  endproperty
  a_reset_abort: assert property (p_reset_abort) else $error("reset did not abandon"); // RULE21

  property p_dead_quiet;
    state_reg == S_DEAD |-> !drive_reg;
  endproperty
  a_dead_quiet: assert property (p_dead_quiet) else $error("line driven while ignoring"); // RULE22

  property p_supply;
    state_reg == S_POWER && ev.start && !ev.smp |=> drive_reg == $past(line_powered);
  endproperty
  a_supply: assert property (p_supply) else $error("supply answer wrong"); // RULE16
endmodule // thermometer_function_commands

/* verification/line_master.sv */
// Bus master model: makes reset, write and read slots on the open-drain line
`timescale 1ns/1ps
module line_master (
  input wire logic clk,
  input wire logic dq,
  output logic pull_low
);
  localparam int US = 25; // Cycles per microsecond at 25 MHz
  localparam int SLOT_US = 61; // Slot plus recovery, kept above the 60 us floor

  // Line released at time zero
  initial pull_low = 1'b0;

  // Write slot: a 1 is released well before the 15 us window opens
  task automatic wr_bit(input logic b);
    @(posedge clk) pull_low <= 1'b1;
    repeat ((b ? 5 : 60) * US) @(posedge clk);
    pull_low <= 1'b0;
    repeat ((SLOT_US - (b ? 5 : 60)) * US) @(posedge clk);
  endtask

  // Whole byte, least significant bit first
  task automatic wr_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      wr_bit(d[i]);
    end
  endtask

  // Read slot: short low start, sample well inside the 15 us valid time
  task automatic rd_bit(output logic b);
    @(posedge clk) pull_low <= 1'b1;
    repeat (2 * US) @(posedge clk);
    pull_low <= 1'b0;
    repeat (10 * US) @(posedge clk);
    b = dq;
    repeat ((SLOT_US - 12) * US) @(posedge clk);
  endtask

  // Byte of read slots, first slot lands in bit 0
  task automatic rd_byte(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      rd_bit(d[i]);
    end
  endtask

  // Reset low time just past 480 us, then idle recovery
  task automatic bus_rst();
    @(posedge clk) pull_low <= 1'b1;
    repeat (490 * US) @(posedge clk);
    pull_low <= 1'b0;
    repeat (10 * US) @(posedge clk);
  endtask
endmodule // line_master

/* verification/thermometer_function_commands_bench.sv */
// Testbench: function command layer driven by a master model on the line
`timescale 1ns/1ps
module thermometer_function_commands_bench import thermo_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic addressed = 1'b0;
  logic rom_cmd_stb = 1'b0;
  logic [7:0] rom_cmd = 8'h00;
  logic alarm_flag = 1'b0;
  logic line_powered = 1'b0;
  logic conv_done = 1'b0;
  logic [15:0] conv_temp = 16'h0000;
  logic nv_rd_done = 1'b0;
  nv_data_t nv_rdata = '0;
  logic pull_low; // Master pulling the line
  logic dq_line; // Resolved wire level
  logic dq_out, dq_oe_n, bus_reset, search_part, conv_start, nv_wr_stb, nv_rd_req;
  nv_data_t nv_wdata, wm_out;
  nv_data_t wr_cap = '0; // Data seen with the store strobe
  int conv_cnt = 0; // Conversion start pulses
  int rst_cnt = 0; // Line reset pulses
  int bad_count = 0;
  int n_tests = 0;

  // Pull-up wins unless someone pulls low; unknown enable counts as released
  assign dq_line = !(pull_low || (dq_oe_n === 1'b0));

  // 40 ns clock
  always #20 clk = ~clk;

  line_master u_master (.clk(clk), .dq(dq_line), .pull_low(pull_low));

  thermometer_function_commands u_dut (
    .clk(clk), .rstn(rstn), .dq_in(dq_line), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .addressed(addressed), .rom_cmd_stb(rom_cmd_stb), .rom_cmd(rom_cmd),
    .alarm_flag(alarm_flag), .line_powered(line_powered), .conv_done(conv_done),
    .conv_temp(conv_temp), .nv_rd_done(nv_rd_done), .nv_rdata(nv_rdata),
    .check_byte(8'h5A), .bus_reset(bus_reset), .search_part(search_part),
    .conv_start(conv_start), .nv_wr_stb(nv_wr_stb), .nv_wdata(nv_wdata),
    .nv_rd_req(nv_rd_req), .wm_out(wm_out)
  );

  // Catchers for one-cycle outputs, so no pulse is missed between slots
  always @(posedge clk) begin
    if (conv_start === 1'b1) conv_cnt <= conv_cnt + 1;
    if (bus_reset === 1'b1) rst_cnt <= rst_cnt + 1;
    if (nv_wr_stb === 1'b1) wr_cap <= nv_wdata;
  end

  // One comparison, four-state exact
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Reload answer from the store model
  task automatic nv_answer(input nv_data_t v);
    @(posedge clk) nv_rd_done <= 1'b1;
    nv_rdata <= v;
    @(posedge clk) nv_rd_done <= 1'b0;
    // Loaded bytes reach wm_out one edge after the working register
    repeat (2) @(posedge clk);
  endtask

  // Six-cycle reset, then serve the power-up reload with v
  task automatic do_reset(input nv_data_t v);
    int i;
    @(posedge clk) rstn <= 1'b0;
    addressed <= 1'b0;
    repeat (6) @(posedge clk);
    chk("oe_in_reset", 24'h000001, 24'(dq_oe_n));
    chk("dq_out", 24'h000000, 24'(dq_out));
    rstn <= 1'b1;
    for (i = 0; i < 20 && nv_rd_req !== 1'b1; i++) @(posedge clk);
    chk("powerup_req", 24'h000001, 24'(nv_rd_req));
    nv_answer(v);
    chk("powerup_wm", v, wm_out);
    addressed <= 1'b1;
  endtask

  // Search takes part: plain always, alarm search only with alarm set
  task automatic t_search();
    do_reset(24'h000000);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) rom_cmd_stb <= 1'b1;
      rom_cmd <= (i == 0) ? CMD_SEARCH : ((i == 3) ? CMD_CONVERT : CMD_ALARM_SEARCH);
      alarm_flag <= (i >= 2);
      @(posedge clk) rom_cmd_stb <= 1'b0;
      repeat (2) @(posedge clk);
      chk("search_part", 24'((i == 0) || (i == 2)), 24'(search_part));
    end
  endtask

  // Reload command: busy slot reads 0, done slot reads 1, bytes replaced
  task automatic t_reload();
    logic b;
    do_reset(24'h3C_A5_18);
    u_master.wr_byte(RELOAD_NONVOLATILE_CMD);
    u_master.rd_bit(b);
    chk("reload_busy", 24'h000000, 24'(b));
    nv_answer(24'h96_0F_E1);
    u_master.rd_bit(b);
    chk("reload_done", 24'h000001, 24'(b));
    chk("reload_wm", 24'h96_0F_E1, wm_out);
  endtask

  // Write memory: three bytes land in th, tl, cfg order
  task automatic t_write();
    do_reset(24'h000000);
    u_master.wr_byte(CMD_WRITE_MEM);
    u_master.wr_byte(8'h7D);
    u_master.wr_byte(8'hC9);
    u_master.wr_byte(8'h3F);
    chk("write_wm", 24'h3F_C9_7D, wm_out);
  endtask

  // Copy: working bytes go to the store, line stays quiet
  task automatic t_copy();
    logic b;
    do_reset(24'h1F_5C_A6);
    // External supply here, so no pullup hold is owed after the command
    u_master.wr_byte(CMD_COPY);
    chk("copy_data", 24'h1F_5C_A6, wr_cap);
    u_master.rd_bit(b);
    chk("copy_quiet", 24'h000001, 24'(b));
  endtask

  // Convert with status, line reset, read cut short by reset, supply query
  task automatic t_convert_read();
    logic b;
    logic [7:0] d;
    do_reset(24'h44_22_11);
    line_powered <= 1'b1;
    u_master.wr_byte(CMD_CONVERT);
    chk("conv_start", 24'h000001, 24'(conv_cnt));
    // Line-powered: line left high as the strong pullup, no slots meanwhile
    repeat (10 * 25) @(posedge clk);
    chk("conv_parasite", 24'h000001, 24'(dq_oe_n));
    // Supply switched to external, so status slots are allowed again
    line_powered <= 1'b0;
    u_master.rd_bit(b);
    chk("conv_busy", 24'h000000, 24'(b));
    @(posedge clk) conv_done <= 1'b1;
    conv_temp <= 16'hA37C;
    @(posedge clk) conv_done <= 1'b0;
    u_master.rd_bit(b);
    chk("conv_done", 24'h000001, 24'(b));
    addressed <= 1'b0;
    u_master.bus_rst();
    chk("line_reset", 24'h000001, 24'(rst_cnt));
    addressed <= 1'b1;
    u_master.wr_byte(CMD_READ_MEM);
    u_master.rd_byte(d);
    chk("temp_lo", 24'h00007C, 24'(d));
    u_master.rd_byte(d);
    chk("temp_hi", 24'h0000A3, 24'(d));
    addressed <= 1'b0;
    u_master.bus_rst();
    chk("abort_reset", 24'h000002, 24'(rst_cnt));
    u_master.rd_bit(b);
    chk("abort_quiet", 24'h000001, 24'(b));
    addressed <= 1'b1;
    line_powered <= 1'b1;
    u_master.wr_byte(CMD_SUPPLY_QUERY);
    u_master.rd_bit(b);
    chk("supply_low", 24'h000000, 24'(b));
    u_master.rd_bit(b);
    chk("supply_once", 24'h000001, 24'(b));
    line_powered <= 1'b0;
  endtask

  // Main sequence
  initial begin
    t_search();
    // Every scenario restarts from reset, so no search is left open
    t_reload();
    t_write();
    t_copy();
    t_convert_read();
    results();
  end

  // Watchdog, sized well past the expected slot count of all scenarios
  initial begin
    repeat (260000) @(posedge clk);
    bad_count++;
    $display("mismatch watchdog expected finish seen hang");
    results();
  end
endmodule // thermometer_function_commands_bench
